// ---- core/event_capture_alert.sv ----
// Event capture and alert logic: enables, status flags, global summary,
// event delay timer and the alert pin driven low on pending events.
// Assumes the serial-port decoder and the event sources run on i_clk_sys.
// Behaviour
// - Clearing any set status bit releases the alert high and starts the delay timer.
// - While the timer runs, events still set flags but the alert stays high.
// - On timer expiry with flags pending the alert goes low again.
// - If nothing is pending at expiry the alert stays high.
// - Status and enable registers can be read at any time.
// - A falling system reset output stops the delay timer at once.
// - Reset, overtemperature or off mode drives the system reset output low.
// - Writing 1 clears a status bit; writing 0 leaves it alone.
// - Global summary flags pending system, supply and transceiver groups; upper bits zero.
// - System flags: power-on bit 4, overtemp bit 2, serial fail bit 1, watchdog bit 0.
// - Supply flags: regulator undervoltage in bit 0, others reserved.
// - Transceiver flags: bus silence bit 4, transceiver failure bit 1, wake-up bit 0.
// - Transceiver failure set on undervoltage or clamped transmit deactivation.
// - Bus wake-up flag set only for wake-ups while the transceiver is offline.
// - System enables: overtemp capture bit 2, serial-port failure capture bit 1.
// - Supply enable: regulator undervoltage capture in bit 0.
// - Transceiver enable: bus silence capture in bit 4, bits 7:5 and 3:2 reserved.
// - Events set flags only when enabled; power-on and watchdog always captured.
// - Captured events pull the alert low while offline with regulator output active.
// - Transceiver enable: failure capture bit 1, wake-up capture bit 0.
`timescale 1ns/1ps
`default_nettype none
module event_capture_alert #(
   parameter int DELAY_CYC = evcap_pkg::EVENT_DELAY_CYC
) (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // Register port from the serial-port decoder
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [evcap_pkg::ADDR_W-1:0] i_reg_addr,
   input wire logic [evcap_pkg::DATA_W-1:0] i_reg_wdata,
   output logic [evcap_pkg::DATA_W-1:0] o_reg_rdata,
   // Event sources, one-cycle pulses
   input wire logic i_evt_power_on,
   input wire logic i_evt_overtemp_warning,
   input wire logic i_evt_serial_port_failure,
   input wire logic i_evt_watchdog_failure,
   input wire logic i_evt_regulator_undervoltage,
   input wire logic i_evt_bus_silence,
   input wire logic i_evt_trx_deact_undervoltage,
   input wire logic i_evt_trx_deact_txd_clamp,
   input wire logic i_evt_bus_wakeup,
   // Operating state levels
   input wire logic i_trx_offline,
   input wire logic i_regulator_output_active,
   input wire logic i_mode_reset,
   input wire logic i_mode_overtemp,
   input wire logic i_mode_off,
   // Pins
   output logic o_alert_n,
   output logic o_system_reset_out_n
);
   import evcap_pkg::*;

   logic [7:0] sys_en_q;
   logic [7:0] sys_en_d;
   logic [7:0] sup_en_q;
   logic [7:0] sup_en_d;
   logic [7:0] trx_en_q;
   logic [7:0] trx_en_d;
   logic [7:0] sys_flags;
   logic [7:0] sup_flags;
   logic [7:0] trx_flags;
   logic [7:0] sys_set;
   logic [7:0] sup_set;
   logic [7:0] trx_set;
   logic [7:0] global_summary;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic sys_clr;
   logic sup_clr;
   logic trx_clr;
   logic any_clr;
   logic any_pending;
   logic timer_running;
   logic timer_stop;
   logic alert_n_q;
   logic alert_n_d;
   logic rst_out_n_q;
   logic rst_out_n_d;
   logic wr_sys_flags;
   logic wr_sup_flags;
   logic wr_trx_flags;

   // Write strobes for the status registers
   assign wr_sys_flags = i_reg_wr && (i_reg_addr == ADDR_SYSTEM_EVENT_FLAGS);
   assign wr_sup_flags = i_reg_wr && (i_reg_addr == ADDR_SUPPLY_EVENT_FLAGS);
   assign wr_trx_flags = i_reg_wr && (i_reg_addr == ADDR_TRANSCEIVER_EVENT_FLAGS);

   // Capture enables; reserved bits never store so they read back as zero
   always_comb begin
      sys_en_d = sys_en_q;
      sup_en_d = sup_en_q;
      trx_en_d = trx_en_q;
      if (i_reg_wr) begin
         case (i_reg_addr)
            ADDR_SYSTEM_EVENT_ENABLE: sys_en_d = i_reg_wdata & MASK_SYSTEM_ENABLE;
            ADDR_SUPPLY_EVENT_ENABLE: sup_en_d = i_reg_wdata & MASK_SUPPLY_ENABLE;
            ADDR_TRANSCEIVER_EVENT_ENABLE: trx_en_d = i_reg_wdata & MASK_TRANSCEIVER_ENABLE;
            default: sys_en_d = sys_en_q;
         endcase
      end
   end

   // Enable registers
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         sys_en_q <= RST_ENABLE;
         sup_en_q <= RST_ENABLE;
         trx_en_q <= RST_ENABLE;
      end else begin
         sys_en_q <= sys_en_d;
         sup_en_q <= sup_en_d;
         trx_en_q <= trx_en_d;
      end
   end

   // Event qualification; power-on and watchdog ignore the enables
   always_comb begin
      sys_set = 8'h00;
      sup_set = 8'h00;
      trx_set = 8'h00;
      sys_set[BIT_POWER_ON] = i_evt_power_on;
      sys_set[BIT_WATCHDOG_FAILURE] = i_evt_watchdog_failure;
      sys_set[BIT_OVERTEMP_WARNING] = i_evt_overtemp_warning && sys_en_q[BIT_OVERTEMP_WARNING];
      sys_set[BIT_SERIAL_PORT_FAILURE] = i_evt_serial_port_failure && sys_en_q[BIT_SERIAL_PORT_FAILURE];
      sup_set[BIT_REGULATOR_UNDERVOLTAGE] = i_evt_regulator_undervoltage
                                            && sup_en_q[BIT_REGULATOR_UNDERVOLTAGE];
      trx_set[BIT_BUS_SILENCE] = i_evt_bus_silence && trx_en_q[BIT_BUS_SILENCE];
      trx_set[BIT_TRANSCEIVER_FAILURE] = (i_evt_trx_deact_undervoltage || i_evt_trx_deact_txd_clamp)
                                         && trx_en_q[BIT_TRANSCEIVER_FAILURE];
      trx_set[BIT_BUS_WAKEUP] = i_evt_bus_wakeup && i_trx_offline && trx_en_q[BIT_BUS_WAKEUP];
   end

   // Status registers, one per event group
   event_flag_reg #(.WIDTH(8), .IMPL_MASK(MASK_SYSTEM_FLAGS)) u_sys_flags (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_set(sys_set),
      .i_wr(wr_sys_flags),
      .i_wdata(i_reg_wdata),
      .o_flags(sys_flags),
      .o_clr_hit(sys_clr)
   );

   event_flag_reg #(.WIDTH(8), .IMPL_MASK(MASK_SUPPLY_FLAGS)) u_sup_flags (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_set(sup_set),
      .i_wr(wr_sup_flags),
      .i_wdata(i_reg_wdata),
      .o_flags(sup_flags),
      .o_clr_hit(sup_clr)
   );

   event_flag_reg #(.WIDTH(8), .IMPL_MASK(MASK_TRANSCEIVER_FLAGS)) u_trx_flags (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_set(trx_set),
      .i_wr(wr_trx_flags),
      .i_wdata(i_reg_wdata),
      .o_flags(trx_flags),
      .o_clr_hit(trx_clr)
   );

   // Group summary, so polling software needs a single read first
   always_comb begin
      global_summary = 8'h00;
      global_summary[BIT_SYSTEM_GROUP_PENDING] = |sys_flags;
      global_summary[BIT_SUPPLY_GROUP_PENDING] = |sup_flags;
      global_summary[BIT_TRANSCEIVER_GROUP_PENDING] = |trx_flags;
   end

   assign any_clr = sys_clr || sup_clr || trx_clr;
   assign any_pending = |global_summary;

   // Reads are served in every state; unmapped addresses answer zero
   always_comb begin
      rdata_d = rdata_q;
      if (i_reg_rd) begin
         case (i_reg_addr)
            ADDR_SYSTEM_EVENT_ENABLE: rdata_d = sys_en_q;
            ADDR_SUPPLY_EVENT_ENABLE: rdata_d = sup_en_q;
            ADDR_TRANSCEIVER_EVENT_ENABLE: rdata_d = trx_en_q;
            ADDR_GLOBAL_EVENT_SUMMARY: rdata_d = global_summary;
            ADDR_SYSTEM_EVENT_FLAGS: rdata_d = sys_flags;
            ADDR_SUPPLY_EVENT_FLAGS: rdata_d = sup_flags;
            ADDR_TRANSCEIVER_EVENT_FLAGS: rdata_d = trx_flags;
            default: rdata_d = 8'h00;
         endcase
      end
   end

   // System reset output; its falling edge also stops the delay timer
   always_comb begin
      rst_out_n_d = !(i_mode_reset || i_mode_overtemp || i_mode_off);
      timer_stop = rst_out_n_q && !rst_out_n_d;
   end

   // Event delay timer, restarted by every clear that drops a bit
   event_delay_timer #(.DELAY_CYC(DELAY_CYC)) u_delay_timer (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_start(any_clr),
      .i_stop(timer_stop),
      .o_running(timer_running)
   );

   // Alert is held back while the timer runs or in the cycle a clear lands,
   // so a burst of events costs the microcontroller one interrupt
   always_comb begin
      alert_n_d = 1'b1;
      if (any_pending && i_trx_offline && i_regulator_output_active
          && !timer_running && !any_clr) begin
         alert_n_d = 1'b0;
      end
   end

   // Output registers
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         alert_n_q <= 1'b1;
         rst_out_n_q <= 1'b0;
         rdata_q <= RST_RDATA;
      end else begin
         alert_n_q <= alert_n_d;
         rst_out_n_q <= rst_out_n_d;
         rdata_q <= rdata_d;
      end
   end

   assign o_alert_n = alert_n_q;
   assign o_system_reset_out_n = rst_out_n_q;
   assign o_reg_rdata = rdata_q;

   // Cycles the delay timer has run since the last clear, for coverage only;
   // a small saturating counter stands in for a long delay range in the cover
   logic [3:0] run_cnt_q;
   logic [3:0] run_cnt_d;

   always_comb begin
      run_cnt_d = run_cnt_q;
      if (any_clr) begin
         run_cnt_d = 4'h0;
      end else if (timer_running && run_cnt_q != 4'hf) begin
         run_cnt_d = run_cnt_q + 4'h1;
      end
   end

   // Coverage counter register
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         run_cnt_q <= 4'h0;
      end else begin
         run_cnt_q <= run_cnt_d;
      end
   end

   // Checks
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   AST_CLEAR_RELEASES: assert property (any_clr && !timer_stop |=> o_alert_n && timer_running)
      else $error("Clear did not release alert and start timer");
   AST_RUN_HOLDS: assert property (timer_running |=> o_alert_n)
      else $error("Alert asserted while delay timer running");
   AST_EXPIRY_ALERTS: assert property ($fell(timer_running) && any_pending && i_trx_offline
                                       && i_regulator_output_active && !any_clr |=> !o_alert_n)
      else $error("Alert not asserted at timer expiry with pending flags");
   AST_EMPTY_HIGH: assert property (!any_pending |=> o_alert_n)
      else $error("Alert low with nothing pending");
   AST_READ_SERVED: assert property (i_reg_rd && i_reg_addr == ADDR_TRANSCEIVER_EVENT_FLAGS
                                     |=> o_reg_rdata == $past(trx_flags))
      else $error("Status read returned wrong data");
   AST_RST_STOPS: assert property ($fell(o_system_reset_out_n) |-> !timer_running)
      else $error("Timer still running after reset output fell");
   AST_MODE_RST_LOW: assert property ((i_mode_reset || i_mode_overtemp || i_mode_off)
                                      |=> !o_system_reset_out_n)
      else $error("Reset output not low in reset mode");
   AST_W1C: assert property (wr_sys_flags && i_reg_wdata[BIT_WATCHDOG_FAILURE] && !i_evt_watchdog_failure
                             |=> !sys_flags[BIT_WATCHDOG_FAILURE])
      else $error("Write one did not clear flag");
   AST_SET_WINS: assert property (wr_sys_flags && i_reg_wdata[BIT_POWER_ON] && i_evt_power_on
                                  |=> sys_flags[BIT_POWER_ON])
      else $error("Event lost against clearing write");
   AST_ENABLE_GATES: assert property (!sys_en_q[BIT_OVERTEMP_WARNING] && !sys_flags[BIT_OVERTEMP_WARNING]
                                      |=> !sys_flags[BIT_OVERTEMP_WARNING])
      else $error("Disabled event was captured");
   AST_WAKE_OFFLINE: assert property (!i_trx_offline && !trx_flags[BIT_BUS_WAKEUP]
                                      |=> !trx_flags[BIT_BUS_WAKEUP])
      else $error("Wake-up flag set while online");
   AST_SUMMARY_READ: assert property (i_reg_rd && i_reg_addr == ADDR_GLOBAL_EVENT_SUMMARY
                                      |=> o_reg_rdata[7:3] == 5'h00
                                          && o_reg_rdata[0] == $past(|sys_flags))
      else $error("Global summary read wrong");
   AST_ALERT_NEEDS_ACTIVE: assert property (!i_regulator_output_active |=> o_alert_n)
      else $error("Alert low without active regulator output");

   COV_CLEAR_THEN_ALERT: cover property (run_cnt_q >= 4'h2 && $fell(o_alert_n));
   COV_SET_AND_CLEAR: cover property (wr_sys_flags && i_evt_power_on && i_reg_wdata[BIT_POWER_ON]);
   COV_RST_STOP: cover property (timer_running ##1 $fell(o_system_reset_out_n));

endmodule : event_capture_alert
`default_nettype wire

// ---- common/evcap_pkg.sv ----
// Package for the event capture and alert logic: register map, field positions,
// reset values and the event delay timing.
// Assumes a 250 MHz system clock and 8-bit registers behind a 7-bit address.
package evcap_pkg;

   // Register port geometry
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;

   // Register offsets
   localparam logic [6:0] ADDR_SYSTEM_EVENT_ENABLE = 7'h04;
   localparam logic [6:0] ADDR_SUPPLY_EVENT_ENABLE = 7'h1c;
   localparam logic [6:0] ADDR_TRANSCEIVER_EVENT_ENABLE = 7'h23;
   localparam logic [6:0] ADDR_GLOBAL_EVENT_SUMMARY = 7'h60;
   localparam logic [6:0] ADDR_SYSTEM_EVENT_FLAGS = 7'h61;
   localparam logic [6:0] ADDR_SUPPLY_EVENT_FLAGS = 7'h62;
   localparam logic [6:0] ADDR_TRANSCEIVER_EVENT_FLAGS = 7'h63;

   // Global summary bit positions
   localparam int BIT_SYSTEM_GROUP_PENDING = 0;
   localparam int BIT_SUPPLY_GROUP_PENDING = 1;
   localparam int BIT_TRANSCEIVER_GROUP_PENDING = 2;

   // System flag and enable bit positions
   localparam int BIT_WATCHDOG_FAILURE = 0;
   localparam int BIT_SERIAL_PORT_FAILURE = 1;
   localparam int BIT_OVERTEMP_WARNING = 2;
   localparam int BIT_POWER_ON = 4;

   // Supply flag and enable bit positions
   localparam int BIT_REGULATOR_UNDERVOLTAGE = 0;

   // Transceiver flag and enable bit positions
   localparam int BIT_BUS_WAKEUP = 0;
   localparam int BIT_TRANSCEIVER_FAILURE = 1;
   localparam int BIT_BUS_SILENCE = 4;

   // Implemented bits; all others are reserved and read as zero
   localparam logic [7:0] MASK_SYSTEM_FLAGS = 8'h17;
   localparam logic [7:0] MASK_SUPPLY_FLAGS = 8'h01;
   localparam logic [7:0] MASK_TRANSCEIVER_FLAGS = 8'h13;
   localparam logic [7:0] MASK_SYSTEM_ENABLE = 8'h06;
   localparam logic [7:0] MASK_SUPPLY_ENABLE = 8'h01;
   localparam logic [7:0] MASK_TRANSCEIVER_ENABLE = 8'h13;

   // Reset values: capture disabled, nothing pending
   localparam logic [7:0] RST_ENABLE = 8'h00;
   localparam logic [7:0] RST_FLAGS = 8'h00;
   localparam logic [7:0] RST_RDATA = 8'h00;

   // Event delay time and its length in clock cycles, rounded up
   localparam int CLK_PERIOD_PS = 4000;
   localparam int EVENT_DELAY_NS = 10000;
   localparam int EVENT_DELAY_CYC = (EVENT_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

endpackage : evcap_pkg

// ---- core/event_flag_reg.sv ----
// One event status register with write-one-to-clear bits.
// Assumes set requests and writes come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module event_flag_reg #(
   parameter int WIDTH = 8,
   parameter logic [WIDTH-1:0] IMPL_MASK = '1
) (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic [WIDTH-1:0] i_set,
   input wire logic i_wr,
   input wire logic [WIDTH-1:0] i_wdata,
   output logic [WIDTH-1:0] o_flags,
   output logic o_clr_hit
);
   logic [WIDTH-1:0] flags_q;
   logic [WIDTH-1:0] flags_d;
   logic [WIDTH-1:0] clr_mask;
   logic [WIDTH-1:0] set_mask;

   // Set beats clear so an event landing on the clearing write is kept
   always_comb begin
      set_mask = i_set & IMPL_MASK;
      clr_mask = i_wr ? i_wdata : '0;
      flags_d = ((flags_q & ~clr_mask) | set_mask) & IMPL_MASK;
      o_clr_hit = |(flags_q & clr_mask & ~set_mask);
   end

   // Flag storage
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         flags_q <= '0;
      end else begin
         flags_q <= flags_d;
      end
   end

   assign o_flags = flags_q;
endmodule : event_flag_reg
`default_nettype wire

// ---- core/event_delay_timer.sv ----
// Event delay timer: runs for a fixed number of cycles after a start.
// Assumes start and stop are one-cycle pulses on the same clock; stop wins.
`timescale 1ns/1ps
`default_nettype none
module event_delay_timer #(
   parameter int DELAY_CYC = 2500
) (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_start,
   input wire logic i_stop,
   output logic o_running
);
   localparam int CNT_W = $clog2(DELAY_CYC + 1);
   localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(DELAY_CYC);

   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;

   // A restart while running reloads the full delay
   always_comb begin
      cnt_d = cnt_q;
      if (i_stop) begin
         cnt_d = '0;
      end else if (i_start) begin
         cnt_d = CNT_LOAD;
      end else if (cnt_q != '0) begin
         cnt_d = cnt_q - CNT_W'(1);
      end
   end

   // Counter register
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign o_running = (cnt_q != '0);
endmodule : event_delay_timer
`default_nettype wire

// ---- dv/host_mcu_model.sv ----
// Host microcontroller model: issues register reads and writes on the byte port.
// Assumes the bench calls its tasks after reset and one request at a time.
`timescale 1ns/1ps
`default_nettype none
module host_mcu_model (
   input wire logic i_clk_sys,
   output logic o_reg_wr,
   output logic o_reg_rd,
   output logic [6:0] o_reg_addr,
   output logic [7:0] o_reg_wdata,
   input wire logic [7:0] i_reg_rdata
);
   // Idle levels at time zero so no strobe is ever unknown
   initial begin
      o_reg_wr = 1'b0;
      o_reg_rd = 1'b0;
      o_reg_addr = 7'h00;
      o_reg_wdata = 8'h00;
   end

   // One-cycle write strobe; a 1 bit clears a flag, a 0 bit leaves it alone
   task automatic write_reg(input logic [6:0] addr, input logic [7:0] data);
      @(posedge i_clk_sys);
      o_reg_wr <= 1'b1;
      o_reg_addr <= addr;
      o_reg_wdata <= data;
      @(posedge i_clk_sys);
      o_reg_wr <= 1'b0;
   endtask : write_reg

   // Read answer lands one cycle after the strobe edge, so sample just after it
   task automatic read_reg(input logic [6:0] addr, output logic [7:0] data);
      @(posedge i_clk_sys);
      o_reg_rd <= 1'b1;
      o_reg_addr <= addr;
      @(posedge i_clk_sys);
      o_reg_rd <= 1'b0;
      #1;
      data = i_reg_rdata;
   endtask : read_reg
endmodule : host_mcu_model
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking bench for the event capture and alert logic.
// Assumes a short event delay parameter so timer expiry is seen quickly.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import evcap_pkg::*;
   localparam int DLY = 8;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [8:0] evt = 9'h000;
   logic trx_offline = 1'b0;
   logic reg_active = 1'b0;
   logic [2:0] modes = 3'h0;
   logic reg_wr, reg_rd, alert_n, reset_out_n;
   logic [6:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, rd_val;
   logic [6:0] tab_addr [9] = '{7'h61, 7'h61, 7'h61, 7'h61, 7'h62, 7'h63, 7'h63, 7'h63, 7'h63};
   logic [7:0] tab_bit [9] = '{8'h10, 8'h04, 8'h02, 8'h01, 8'h01, 8'h10, 8'h02, 8'h02, 8'h01};
   logic [6:0] all_addr [8] = '{7'h04, 7'h1c, 7'h23, 7'h60, 7'h61, 7'h62, 7'h63, 7'h7e};
   int failures = 0;
   int checks = 0;

   // 250 MHz system clock
   always #2 clk_sys = ~clk_sys;

   host_mcu_model u_host (.i_clk_sys(clk_sys), .o_reg_wr(reg_wr), .o_reg_rd(reg_rd),
      .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata), .i_reg_rdata(reg_rdata));

   event_capture_alert #(.DELAY_CYC(DLY)) u_dut (
      .i_clk_sys(clk_sys), .i_rst(rst), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
      .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata),
      .i_evt_power_on(evt[0]), .i_evt_overtemp_warning(evt[1]), .i_evt_serial_port_failure(evt[2]),
      .i_evt_watchdog_failure(evt[3]), .i_evt_regulator_undervoltage(evt[4]),
      .i_evt_bus_silence(evt[5]), .i_evt_trx_deact_undervoltage(evt[6]),
      .i_evt_trx_deact_txd_clamp(evt[7]), .i_evt_bus_wakeup(evt[8]),
      .i_trx_offline(trx_offline), .i_regulator_output_active(reg_active),
      .i_mode_reset(modes[0]), .i_mode_overtemp(modes[1]), .i_mode_off(modes[2]),
      .o_alert_n(alert_n), .o_system_reset_out_n(reset_out_n));

   task automatic conclude;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : conclude

   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic rd_check(input logic [6:0] addr, input logic [7:0] exp);
      u_host.read_reg(addr, rd_val);
      check(rd_val, exp, $sformatf("read %h", addr));
   endtask : rd_check

   // One-cycle event pulse, taken at the second edge
   task automatic fire(input logic [8:0] mask);
      @(posedge clk_sys);
      evt <= mask;
      @(posedge clk_sys);
      evt <= 9'h000;
   endtask : fire

   // Bounded wait for the alert pin; running out of cycles ends the run
   task automatic wait_alert(input logic level, input int bound);
      int n;
      n = 0;
      #1;
      while (alert_n !== level && n < bound) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      check({7'h00, alert_n}, {7'h00, level}, "alert pin level");
      if (alert_n !== level) conclude();
   endtask : wait_alert

   task automatic cycles(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : cycles

   initial begin
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      cycles(2);
      // Everything idle after reset, unmapped address reads zero
      check({7'h00, reset_out_n}, 8'h01, "reset output");
      check({7'h00, alert_n}, 8'h01, "alert idle");
      foreach (all_addr[i]) rd_check(all_addr[i], 8'h00);
      $display("test reset_values done");
      // Only power-on and watchdog are captured with every enable off
      fire(9'h1ff);
      rd_check(7'h61, 8'h11);
      rd_check(7'h62, 8'h00);
      rd_check(7'h63, 8'h00);
      rd_check(7'h60, 8'h01);
      u_host.write_reg(7'h61, 8'hff);
      rd_check(7'h61, 8'h00);
      $display("test capture_gating done");
      // Enables keep only their implemented bits; the summary ignores writes
      u_host.write_reg(7'h04, 8'hff);
      u_host.write_reg(7'h1c, 8'hff);
      u_host.write_reg(7'h23, 8'hff);
      u_host.write_reg(7'h60, 8'hff);
      rd_check(7'h04, 8'h06);
      rd_check(7'h1c, 8'h01);
      rd_check(7'h23, 8'h13);
      rd_check(7'h60, 8'h00);
      $display("test enable_fields done");
      // Each source lands on its bit, both transceiver deactivation causes on one; a zero write keeps it, a one clears it
      @(posedge clk_sys) trx_offline <= 1'b1;
      foreach (tab_bit[i]) begin
         fire(9'h001 << i);
         rd_check(tab_addr[i], tab_bit[i]);
         check({7'h00, alert_n}, 8'h01, "alert needs regulator");
         rd_check(7'h60, 8'h01 << (tab_addr[i] - 7'h61));
         u_host.write_reg(tab_addr[i], 8'h00);
         rd_check(tab_addr[i], tab_bit[i]);
         u_host.write_reg(tab_addr[i], tab_bit[i]);
         rd_check(tab_addr[i], 8'h00);
      end
      @(posedge clk_sys) trx_offline <= 1'b0;
      fire(9'h100);
      rd_check(7'h63, 8'h00);
      $display("test event_bits done");
      // Alert pacing by the event delay timer
      @(posedge clk_sys) trx_offline <= 1'b1;
      reg_active <= 1'b1;
      fire(9'h001);
      wait_alert(1'b0, 4);
      u_host.write_reg(7'h61, 8'h10);
      wait_alert(1'b1, 0);
      fire(9'h002);
      rd_check(7'h61, 8'h04);
      check({7'h00, alert_n}, 8'h01, "alert held by timer");
      wait_alert(1'b0, DLY + 4);
      u_host.write_reg(7'h61, 8'h04);
      fire(9'h008);
      u_host.write_reg(7'h61, 8'h01);
      cycles(DLY + 4);
      check({7'h00, alert_n}, 8'h01, "alert after empty expiry");
      rd_check(7'h60, 8'h00);
      $display("test alert_timer done");
      // A set in the same cycle as its clearing write survives
      fire(9'h001);
      fork
         u_host.write_reg(7'h61, 8'h10);
         fire(9'h001);
      join
      rd_check(7'h61, 8'h10);
      u_host.write_reg(7'h61, 8'h10);
      cycles(DLY + 4);
      $display("test set_wins done");
      // Falling reset output cuts the timer short so the alert returns early
      fire(9'h009);
      wait_alert(1'b0, 4);
      u_host.write_reg(7'h61, 8'h10);
      @(posedge clk_sys);
      modes <= 3'h1;
      wait_alert(1'b0, 3);
      check({7'h00, reset_out_n}, 8'h00, "reset output in reset mode");
      @(posedge clk_sys) modes <= 3'h0;
      u_host.write_reg(7'h61, 8'h01);
      cycles(DLY + 4);
      $display("test timer_stop done");
      // Each of the three modes pulls the reset output low
      for (int m = 0; m < 3; m++) begin
         @(posedge clk_sys);
         modes <= 3'h1 << m;
         cycles(2);
         check({7'h00, reset_out_n}, 8'h00, "reset output low");
         @(posedge clk_sys) modes <= 3'h0;
         cycles(2);
         check({7'h00, reset_out_n}, 8'h01, "reset output high");
      end
      $display("test reset_output done");
      conclude();
   end
endmodule : tb_top
`default_nettype wire
